// ---- src/bvc_regs.sv ----
/*
 Control registers of the core and MPU step-down converters: stored
 control bytes, applied voltage codes, target millivolts, forced-PWM and
 pulse-skip controls, and supervision blanking after each accepted write.
 Assumes a register port decoded from the serial management bus, a level
 from the password logic saying writes are unlocked, and one-cycle pulses
 from the apply register (apply and apply-without-supervision).
*/
module bvc_regs #(
   parameter int unsigned BLANK_CYCLES = bvc_pkg::BLANK_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regWrRefused,
   input wire logic writeUnlocked,
   input wire logic voltageApply,
   input wire logic voltageApplyNoSupervise,
   output logic corePulseSkipEnable,
   output logic corePwmForced,
   output logic [5:0] coreVoltCode,
   output logic [10:0] coreTargetMv,
   output logic coreSuperviseBlank,
   output logic mpuPulseSkipEnable,
   output logic mpuPwmForced,
   output logic [5:0] mpuVoltCode,
   output logic [10:0] mpuTargetMv,
   output logic mpuSuperviseBlank
);
   localparam int NCONV = 2;
   localparam int CORE = 0;
   localparam int MPU = 1;

   // Shared mapping for both converters
   function automatic logic [10:0] code_to_mv(input logic [5:0] code);
      logic [10:0] steps;
      steps = 11'h000;
      if (code <= bvc_pkg::KNEE_CODE) begin
         steps = {5'h00, code};
         code_to_mv = bvc_pkg::BASE_MV + 11'(steps * bvc_pkg::FINE_STEP_MV);
      end else begin
         steps = {5'h00, code - bvc_pkg::KNEE_CODE};
         code_to_mv = bvc_pkg::KNEE_MV + 11'(steps * bvc_pkg::COARSE_STEP_MV);
      end
   endfunction

   function automatic int addr_to_conv(input logic [7:0] addr);
      if (addr == bvc_pkg::CORE_BUCK_CONTROL_ADDR) begin
         addr_to_conv = CORE;
      end else if (addr == bvc_pkg::MPU_BUCK_CONTROL_ADDR) begin
         addr_to_conv = MPU;
      end else begin
         addr_to_conv = -1;
      end
   endfunction

   logic [7:0] ctrl_ff [NCONV];
   logic [7:0] nxt_ctrl [NCONV];
   logic [5:0] applied_ff [NCONV];
   logic [5:0] nxt_applied [NCONV];
   logic [10:0] mv_ff [NCONV];
   logic [10:0] nxt_mv [NCONV];
   logic pskip_ff [NCONV];
   logic nxt_pskip [NCONV];
   logic pwm_ff [NCONV];
   logic nxt_pwm [NCONV];
   logic [7:0] rd_ff;
   logic [7:0] nxt_rd;
   logic refused_ff;
   logic nxt_refused;
   logic wrAccept [NCONV];
   logic blank [NCONV];

   // Register write, apply and mode control
   always_comb begin
      int sel;
      logic apply;
      sel = addr_to_conv(regAddr);
      apply = voltageApply | voltageApplyNoSupervise;
      nxt_refused = 1'b0;
      for (int i = 0; i < NCONV; i++) begin
         nxt_ctrl[i] = ctrl_ff[i];
         nxt_applied[i] = applied_ff[i];
         wrAccept[i] = 1'b0;
         if (regWrEn && sel == i) begin
            // [RQ6] refuse locked writes
            if (writeUnlocked) begin
               wrAccept[i] = 1'b1;
               // [RQ11] reserved bit dropped
               nxt_ctrl[i] = regWrData & bvc_pkg::WRITABLE_MASK;
            end else begin
               nxt_refused = 1'b1;
            end
         end
         // [RQ9] [RQ10] code applied on apply
         if (apply) begin
            nxt_applied[i] = nxt_ctrl[i][bvc_pkg::CODE_MSB:0];
         end
         // [RQ4] [RQ5] code to millivolts
         nxt_mv[i] = code_to_mv(nxt_applied[i]);
         // [RQ3] pulse-skip versus forced PWM
         nxt_pskip[i] = nxt_ctrl[i][bvc_pkg::PULSE_SKIP_BIT];
         nxt_pwm[i] = ~nxt_ctrl[i][bvc_pkg::PULSE_SKIP_BIT];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NCONV; i++) begin
            // [RQ1] [RQ2] reset value 0x99
            ctrl_ff[i] <= bvc_pkg::BUCK_CONTROL_RESET;
            applied_ff[i] <= bvc_pkg::BUCK_CONTROL_RESET[bvc_pkg::CODE_MSB:0];
            mv_ff[i] <= code_to_mv(bvc_pkg::BUCK_CONTROL_RESET[bvc_pkg::CODE_MSB:0]);
            pskip_ff[i] <= bvc_pkg::BUCK_CONTROL_RESET[bvc_pkg::PULSE_SKIP_BIT];
            pwm_ff[i] <= ~bvc_pkg::BUCK_CONTROL_RESET[bvc_pkg::PULSE_SKIP_BIT];
         end
         refused_ff <= 1'b0;
      end else begin
         for (int i = 0; i < NCONV; i++) begin
            ctrl_ff[i] <= nxt_ctrl[i];
            applied_ff[i] <= nxt_applied[i];
            mv_ff[i] <= nxt_mv[i];
            pskip_ff[i] <= nxt_pskip[i];
            pwm_ff[i] <= nxt_pwm[i];
         end
         refused_ff <= nxt_refused;
      end
   end

   // Read path: registered, one cycle after the strobe
   always_comb begin
      int sel;
      sel = addr_to_conv(regAddr);
      nxt_rd = rd_ff;
      if (regRdEn) begin
         // [RQ1] [RQ2] address decode
         if (sel == CORE) begin
            nxt_rd = ctrl_ff[CORE];
         end else if (sel == MPU) begin
            nxt_rd = ctrl_ff[MPU];
         end else begin
            nxt_rd = bvc_pkg::UNMAPPED_READ;
         end
         // [RQ11] reserved bit reads zero
         nxt_rd[bvc_pkg::RESERVED_BIT] = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_ff <= 8'h00;
      end else begin
         rd_ff <= nxt_rd;
      end
   end

   // [RQ7] core write blanks supervision
   bvc_blank_timer #(
      .CYCLES(BLANK_CYCLES)
   ) u_core_blank (
      .mclk(mclk),
      .resetn(resetn),
      .start(wrAccept[CORE]),
      .blank(blank[CORE])
   );

   // [RQ8] MPU write blanks supervision
   bvc_blank_timer #(
      .CYCLES(BLANK_CYCLES)
   ) u_mpu_blank (
      .mclk(mclk),
      .resetn(resetn),
      .start(wrAccept[MPU]),
      .blank(blank[MPU])
   );

   assign regRdData = rd_ff;
   assign regWrRefused = refused_ff;
   assign corePulseSkipEnable = pskip_ff[CORE];
   assign corePwmForced = pwm_ff[CORE];
   assign coreVoltCode = applied_ff[CORE];
   assign coreTargetMv = mv_ff[CORE];
   assign coreSuperviseBlank = blank[CORE];
   assign mpuPulseSkipEnable = pskip_ff[MPU];
   assign mpuPwmForced = pwm_ff[MPU];
   assign mpuVoltCode = applied_ff[MPU];
   assign mpuTargetMv = mv_ff[MPU];
   assign mpuSuperviseBlank = blank[MPU];
endmodule

// ---- include/bvc_pkg.sv ----
/*
 Constants for the buck voltage control register bank: offsets, field
 positions, reset values, voltage mapping and the supervision blanking time.
 Assumes a single clock mclk of 10 MHz.
*/
// Function
// [RQ1] Core control at 0x16, reset 0x99
// [RQ2] MPU control at 0x17, reset 0x99
// [RQ3] Pulse-skip bit clear forces PWM operation
// [RQ4] Core code: 0.850 V, 10/25 mV steps
// [RQ5] MPU code uses same voltage mapping
// [RQ6] Writes refused unless password unlock done
// [RQ7] Core write blanks supervision for 5 ms
// [RQ8] MPU write blanks supervision for 5 ms
// [RQ9] Core voltage applies only on apply bits
// [RQ10] MPU voltage applies only on apply bits
// [RQ11] Reserved bit 6 ignored, reads zero
package bvc_pkg;
   localparam logic [7:0] CORE_BUCK_CONTROL_ADDR = 8'h16;
   localparam logic [7:0] MPU_BUCK_CONTROL_ADDR = 8'h17;
   localparam logic [7:0] BUCK_CONTROL_RESET = 8'h99;
   localparam int PULSE_SKIP_BIT = 7;
   localparam int RESERVED_BIT = 6;
   localparam int CODE_MSB = 5;
   localparam int CODE_W = 6;
   localparam logic [7:0] WRITABLE_MASK = 8'hBF;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // Voltage mapping in millivolts
   localparam int MV_W = 11;
   localparam logic [10:0] BASE_MV = 11'h352;
   localparam logic [10:0] FINE_STEP_MV = 11'h00A;
   localparam logic [10:0] KNEE_MV = 11'h546;
   localparam logic [10:0] COARSE_STEP_MV = 11'h019;
   localparam logic [5:0] KNEE_CODE = 6'h32;
   // Supervision blanking: least time, rounded up
   localparam int BLANK_TIME_US = 5000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int BLANK_CYCLES = (BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_CNT_W = 16;
endpackage

// ---- src/bvc_blank_timer.sv ----
/*
 Supervision blanking timer: a start pulse holds the blank output high for
 CYCLES clocks; a new start restarts the full period.
 Assumes start is synchronous to mclk.
*/
module bvc_blank_timer #(
   parameter int unsigned CYCLES = bvc_pkg::BLANK_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic start,
   output logic blank
);
   localparam int W = bvc_pkg::BLANK_CNT_W;

   if (CYCLES < 1 || CYCLES > (2 ** W) - 1) begin : g_bad_cycles
      $error("blank timer CYCLES out of range");
   end

   logic [W-1:0] count_ff;
   logic [W-1:0] nxt_count;
   logic blank_ff;
   logic nxt_blank;

   always_comb begin
      nxt_count = count_ff;
      if (start) begin
         nxt_count = W'(CYCLES);
      end else if (count_ff != '0) begin
         nxt_count = count_ff - W'(1);
      end
      nxt_blank = (nxt_count != '0);
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_ff <= '0;
         blank_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         blank_ff <= nxt_blank;
      end
   end

   assign blank = blank_ff;
endmodule

// ---- test/bvc_regs_props.sv ----
/*
 Port checker for bvc_regs, bound into every instance.
 Assumes one clock mclk and an async active-low resetn.
*/
module bvc_regs_props #(
   parameter int unsigned BLANK_CYCLES = 20
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regRdData,
   input wire logic regWrRefused,
   input wire logic writeUnlocked,
   input wire logic voltageApply,
   input wire logic voltageApplyNoSupervise,
   input wire logic corePulseSkipEnable,
   input wire logic corePwmForced,
   input wire logic [5:0] coreVoltCode,
   input wire logic [10:0] coreTargetMv,
   input wire logic coreSuperviseBlank,
   input wire logic mpuPulseSkipEnable,
   input wire logic mpuPwmForced,
   input wire logic [5:0] mpuVoltCode,
   input wire logic mpuSuperviseBlank
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_core_pwm: assert property (corePwmForced != corePulseSkipEnable)
      else $error("core pwm mode wrong");
   a_mpu_pwm: assert property (mpuPwmForced != mpuPulseSkipEnable)
      else $error("mpu pwm mode wrong");
   a_core_mv_map: assert property (coreTargetMv == ((coreVoltCode <= 6'h32) ?
      11'h352 + 11'h00A * coreVoltCode : 11'h546 + 11'h019 * (coreVoltCode - 6'h32)))
      else $error("core millivolts wrong");
   a_locked_refuse: assert property (regWrEn && !writeUnlocked &&
      regAddr[7:1] == 7'h0B |=> regWrRefused && $stable(corePulseSkipEnable))
      else $error("locked write not refused");
   a_core_blank: assert property (regWrEn && writeUnlocked && regAddr == 8'h16
      |=> coreSuperviseBlank[*2]) else $error("core blank missing");
   a_mpu_blank: assert property (regWrEn && writeUnlocked && regAddr == 8'h17
      |=> mpuSuperviseBlank) else $error("mpu blank missing");
   a_core_code_hold: assert property (!voltageApply && !voltageApplyNoSupervise
      |=> $stable(coreVoltCode)) else $error("core code moved");
   a_mpu_code_hold: assert property (!voltageApply && !voltageApplyNoSupervise
      |=> $stable(mpuVoltCode)) else $error("mpu code moved");
   a_reserved_zero: assert property (regRdEn |=> !regRdData[6])
      else $error("reserved bit read high");
   cover property (regWrRefused);
   cover property ($fell(coreSuperviseBlank));
   cover property (voltageApplyNoSupervise);
endmodule
bind bvc_regs bvc_regs_props #(.BLANK_CYCLES(BLANK_CYCLES)) props_u (.mclk, .resetn,
   .regWrEn, .regRdEn, .regAddr, .regRdData, .regWrRefused, .writeUnlocked, .voltageApply,
   .voltageApplyNoSupervise, .corePulseSkipEnable, .corePwmForced, .coreVoltCode,
   .coreTargetMv, .coreSuperviseBlank, .mpuPulseSkipEnable, .mpuPwmForced, .mpuVoltCode,
   .mpuSuperviseBlank);

// ---- test/bvc_host_model.sv ----
/*
 Host side model: password unlock level and apply pulses.
 Assumes requests from the bench arrive on mclk edges.
*/
module bvc_host_model (
   input wire logic mclk,
   input wire logic unlock,
   input wire logic [1:0] applyReq,
   output logic writeUnlocked,
   output logic voltageApply,
   output logic voltageApplyNoSupervise
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge mclk) begin
      writeUnlocked <= unlock;
      voltageApply <= applyReq[0];
      voltageApplyNoSupervise <= applyReq[1];
   end
endmodule

// ---- test/tb_top.sv ----
/*
 Self-checking bench for bvc_regs with a short blanking count.
 Assumes the host model supplies unlock and apply pulses.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, resetn = 0, regWrEn = 0, regRdEn = 0, unlock = 0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
   logic [1:0] applyReq = 2'h0;
   logic regWrRefused, writeUnlocked, voltageApply, voltageApplyNoSupervise;
   logic corePulseSkipEnable, corePwmForced, coreSuperviseBlank;
   logic mpuPulseSkipEnable, mpuPwmForced, mpuSuperviseBlank;
   logic [5:0] coreVoltCode, mpuVoltCode;
   logic [10:0] coreTargetMv, mpuTargetMv;
   int failures = 0, comparisons = 0, n;
   always #50 mclk = ~mclk;
   bvc_host_model host_u (.mclk, .unlock, .applyReq, .writeUnlocked, .voltageApply,
      .voltageApplyNoSupervise);
   bvc_regs #(.BLANK_CYCLES(20)) dut_u (.mclk, .resetn, .regWrEn, .regRdEn, .regAddr,
      .regWrData, .regRdData, .regWrRefused, .writeUnlocked, .voltageApply,
      .voltageApplyNoSupervise, .corePulseSkipEnable, .corePwmForced, .coreVoltCode,
      .coreTargetMv, .coreSuperviseBlank, .mpuPulseSkipEnable, .mpuPwmForced,
      .mpuVoltCode, .mpuTargetMv, .mpuSuperviseBlank);
   task chk(input logic [10:0] seen, input logic [10:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWrEn <= 1'b0;
      @(negedge mclk);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRdEn <= 1'b0;
      @(negedge mclk);
      chk({3'h0, regRdData}, {3'h0, e});
   endtask
   // Model adds one cycle before the pulse reaches the block
   task apply(input logic [1:0] k);
      @(posedge mclk);
      applyReq <= k;
      @(posedge mclk);
      applyReq <= 2'h0;
      @(posedge mclk);
      @(negedge mclk);
   endtask
   task results;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      rd(8'h16, 8'h99);
      rd(8'h17, 8'h99);
      chk(coreTargetMv, 11'h44C);
      chk(corePulseSkipEnable, 1'b1);
      wr(8'h16, 8'h00);
      chk(regWrRefused, 1'b1);
      rd(8'h16, 8'h99);
      @(posedge mclk) unlock <= 1'b1;
      wr(8'h16, 8'h7F);
      n = 0;
      // Bounded window; blank must cover exactly the set count
      repeat (40) begin
         if (coreSuperviseBlank === 1'b1) n++;
         @(negedge mclk);
      end
      chk(n[10:0], 11'h014);
      chk(corePwmForced, 1'b1);
      chk(corePulseSkipEnable, 1'b0);
      chk(coreVoltCode, 6'h19);
      rd(8'h16, 8'h3F);
      apply(2'h1);
      chk(coreVoltCode, 6'h3F);
      chk(coreTargetMv, 11'h68B);
      wr(8'h17, 8'h23);
      chk(mpuSuperviseBlank, 1'b1);
      chk(mpuPulseSkipEnable, 1'b0);
      chk(mpuPwmForced, 1'b1);
      chk(mpuVoltCode, 6'h19);
      apply(2'h2);
      chk(mpuVoltCode, 6'h23);
      chk(mpuTargetMv, 11'h4B0);
      rd(8'h18, 8'h00);
      // Mid-run reset drops stored codes and a running blank
      @(posedge mclk) resetn <= 1'b0;
      @(negedge mclk);
      chk(mpuSuperviseBlank, 1'b0);
      chk(mpuVoltCode, 6'h19);
      chk(mpuTargetMv, 11'h44C);
      chk(mpuPulseSkipEnable, 1'b1);
      @(posedge mclk) resetn <= 1'b1;
      rd(8'h17, 8'h99);
      results();
   end
endmodule
